// [src/phyctl_regs.sv]
// Purpose: Reset, clock phase, regulator and cable-length control registers.
// Assumes: APB slave with no wait states; inputs synchronous to CLK.
// Notes:   Software reset clears every register, restart clears none.
//
// What this block does
// - Software reset bit resets whole device
// - Restart bit resets circuitry, keeps registers
// - Reserved read-only bits ignore writes, read zero
// - Transmit clock phase fixed except programmed shifts
// - Phase field holds offset in 4 ns steps
// - New value shifts clock by value difference
// - Values above ten stored modulo ten
// - Phase enable bit applies value, self-clears
// - Phase field reads the applied offset
// - Regulator power-down bit, self-clearing
// - Averaging factor resets to one; start self-clears
//
// The APB slave port was left to the implementer.
module phyctl_regs
	import phyctl_pkg::*;
(
	input  wire logic        CLK,
	input  wire logic        RESETN,
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [11:0] PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	output logic             CORE_RESETN,
	output logic             RESTART_N,
	output logic      [3:0]  TX_PHASE,
	output logic             TX_PHASE_STEP,
	output logic             TX_PHASE_UP,
	output logic             REG_POWER_DOWN,
	output logic      [3:0]  REG_CTRL,
	output logic             CLD_START,
	output logic      [2:0]  CLD_AVG,
	input  wire logic        CLD_DONE,
	input  wire logic        CLD_RESULT_VALID,
	input  wire logic [7:0]  CLD_RESULT
);

	phyctl_rst_t clr;            // Clear levels from the sequencer.
	logic        setup;          // APB setup cycle.
	logic        wr;             // Write that takes effect this edge.
	logic [3:0]  phase_value;    // Programmed phase, already folded.
	logic [3:0]  next_phase;     // Folded value of the write data.
	logic [3:0]  applied;        // Phase the delay line holds now.
	logic        wr_rst;         // Write to the reset control register.
	logic        wr_phase;       // Write to the phase register.
	logic        wr_vr;          // Write to the regulator register.
	logic        wr_cld;         // Write to the cable diagnostic register.
	logic        phase_go;       // Phase enable written with one.
	logic [10:0] vr_rsvd;        // Regulator reserved bits, read-write.
	logic [3:0]  vr_ctrl;        // Regulator control field.
	logic [7:0]  cld_result;     // Last diagnostic measurement.
	logic [31:0] next_rdata;     // Read data chosen in the setup cycle.
	logic        next_err;       // Unmapped address in the setup cycle.

	// The slave never waits, so the access phase is always its last.
	assign PREADY = 1'b1;
	assign setup  = PSEL && !PENABLE;
	assign wr     = PSEL && PENABLE && PWRITE && PREADY && !PSLVERR;

	// Address decode of the writes.
	assign wr_rst   = wr && (PADDR == ADDR_RST);
	assign wr_phase = wr && (PADDR == ADDR_PHASE);
	assign wr_vr    = wr && (PADDR == ADDR_VR);
	assign wr_cld   = wr && (PADDR == ADDR_CLD);

	assign next_phase = phyctl_mod10(PWDATA[PH_MSB:0]);
	assign phase_go   = wr_phase && PWDATA[BIT_PH_EN];

	// The hardware pin and the software reset reach the core alike.
	assign CORE_RESETN = RESETN && !clr.core_clr;
	assign RESTART_N   = RESETN && !clr.circ_clr;
	assign TX_PHASE    = applied;
	assign REG_CTRL    = vr_ctrl;

	// Sequencer holds the clears for a fixed time after a request.
	phyctl_rstseq #(
		.HOLD     (RESET_HOLD_CYC)
	) u_rstseq (
		.clk      (CLK),
		.resetn   (RESETN),
		.sw_reset (wr_rst && PWDATA[BIT_SWRST]),
		.restart  (wr_rst && PWDATA[BIT_RESTART]),
		.clr      (clr)
	);

	// The stepper belongs to the register state, so only reset clears it.
	phyctl_phstep #(
		.GAP     (STEP_GAP_CYC)
	) u_phstep (
		.clk     (CLK),
		.resetn  (RESETN),
		.clr     (clr.core_clr),
		.go      (phase_go),
		.target  (wr_phase ? next_phase : phase_value),
		.applied (applied),
		.step    (TX_PHASE_STEP),
		.up      (TX_PHASE_UP)
	);

	// Programmed phase value; a software reset returns it to zero.
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			phase_value <= PHASE_RST;
		end else if (clr.core_clr) begin
			phase_value <= PHASE_RST;
		end else if (wr_phase) begin
			phase_value <= next_phase;
		end
	end

	// Regulator register. Power-down stays latched, since the bit that
	// asked for it reads back zero and the regulator must stay off.
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			REG_POWER_DOWN <= 1'b0;
			vr_rsvd        <= VR_RSVD_RST;
			vr_ctrl        <= VR_CTRL_RST;
		end else if (clr.core_clr) begin
			REG_POWER_DOWN <= 1'b0;
			vr_rsvd        <= VR_RSVD_RST;
			vr_ctrl        <= VR_CTRL_RST;
		end else if (wr_vr) begin
			REG_POWER_DOWN <= REG_POWER_DOWN || PWDATA[BIT_VR_PD];
			vr_rsvd        <= PWDATA[VRR_MSB:VRR_LSB];
			vr_ctrl        <= PWDATA[VRC_MSB:0];
		end
	end

	// Cable diagnostic controls: a one-cycle start and the averaging factor.
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			CLD_START <= 1'b0;
			CLD_AVG   <= CLD_AVG_RST;
		end else if (clr.core_clr) begin
			CLD_START <= 1'b0;
			CLD_AVG   <= CLD_AVG_RST;
		end else begin
			CLD_START <= wr_cld && PWDATA[BIT_CLD_START];
			if (wr_cld) begin
				CLD_AVG <= PWDATA[AVG_MSB:0];
			end
		end
	end

	// The result field follows the engine and software reset; writes to its register never reach it.
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			cld_result <= CLD_RES_RST;
		end else if (clr.core_clr) begin
			cld_result <= CLD_RES_RST;
		end else if (CLD_RESULT_VALID) begin
			cld_result <= CLD_RESULT;
		end
	end

	// Read mux; self-clearing bits and all reserved bits but the regulator's read as zero.
	always_comb begin
		next_rdata = '0;
		next_err   = 1'b0;
		if (PADDR == ADDR_RST) begin
			next_rdata = '0;
		end else if (PADDR == ADDR_PHASE) begin
			next_rdata[PH_MSB:0] = applied;
		end else if (PADDR == ADDR_VR) begin
			next_rdata[VRR_MSB:VRR_LSB] = vr_rsvd;
			next_rdata[VRC_MSB:0]       = vr_ctrl;
		end else if (PADDR == ADDR_CLD) begin
			next_rdata[BIT_CLD_DONE]      = CLD_DONE;
			next_rdata[RES_MSB:RES_LSB]   = cld_result;
			next_rdata[AVG_MSB:0]         = CLD_AVG;
		end else begin
			next_err = 1'b1;
		end
	end

	// Answer is captured in the setup cycle so it stands all access long.
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			PRDATA  <= '0;
			PSLVERR <= 1'b0;
		end else if (setup) begin
			PRDATA  <= PWRITE ? 32'h0000_0000 : next_rdata;
			PSLVERR <= next_err;
		end else if (!PSEL) begin
			PSLVERR <= 1'b0;
		end
	end

	default clocking @(posedge CLK); endclocking
	default disable iff (!RESETN);

	chk_swreset_hold: assert property (
		wr_rst && PWDATA[BIT_SWRST] |=> !CORE_RESETN [*8])
		else $error("Software reset was not held.");
	// The clear level rises at the write edge and empties the registers
	// at the edge after it, so the contents are looked at one cycle later.
	chk_swreset_clears: assert property (
		wr_rst && PWDATA[BIT_SWRST] |=> ##1 CLD_AVG == CLD_AVG_RST
			&& phase_value == PHASE_RST && !REG_POWER_DOWN)
		else $error("Software reset left register contents.");
	chk_restart_keeps: assert property (
		wr_rst && PWDATA[BIT_RESTART] && !PWDATA[BIT_SWRST]
			&& CORE_RESETN |=> !RESTART_N && $stable(CLD_AVG)
			&& $stable(vr_ctrl))
		else $error("Restart disturbed the registers.");
	chk_rsvd_zero: assert property (
		setup && !PWRITE && PADDR == ADDR_PHASE |=> PRDATA[31:4] == '0)
		else $error("Reserved phase bits read nonzero.");
	chk_phase_fold: assert property (
		wr_phase && !clr.core_clr |=> phase_value < PHASE_LIMIT
			&& phase_value == phyctl_mod10($past(PWDATA[PH_MSB:0])))
		else $error("Phase value was not folded modulo ten.");
	chk_phase_read: assert property (
		setup && !PWRITE && PADDR == ADDR_PHASE
			|=> PRDATA[PH_MSB:0] == $past(applied))
		else $error("Phase read did not show applied phase.");
	chk_power_down: assert property (
		wr_vr && PWDATA[BIT_VR_PD] && !clr.core_clr |=> REG_POWER_DOWN)
		else $error("Regulator was not powered down.");
	chk_start_pulse: assert property (
		wr_cld && PWDATA[BIT_CLD_START] && !clr.core_clr
			|=> CLD_START ##1 !CLD_START)
		else $error("Diagnostic start was not a single pulse.");
	chk_result_hold: assert property (
		!CLD_RESULT_VALID && !clr.core_clr |=> $stable(cld_result))
		else $error("Result changed without the engine.");
	chk_phase_reach: assert property (
		phase_go && !clr.core_clr |-> ##[1:60] applied == phase_value)
		else $error("Applied phase never reached the value.");

	cov_phase_move: cover property (phase_go ##[1:60] TX_PHASE_STEP);
	cov_swreset: cover property (wr_rst && PWDATA[BIT_SWRST]);
	cov_cld_result: cover property (CLD_START ##[1:50] CLD_RESULT_VALID);
	cov_unmapped: cover property (PSEL && PENABLE && PSLVERR);

endmodule : phyctl_regs

// [shared/phyctl_pkg.sv]
// Purpose: Shared constants and types of the transceiver control registers.
// Assumes: One 100 MHz clock; APB with 32-bit data, one word per register.
// Notes:   Printed offsets are register indexes; byte address is index * 4.
package phyctl_pkg;

	// Clock period of the single domain, in nanoseconds.
	localparam int CLK_PERIOD_NS = 10;

	// Register indexes and the byte addresses derived from them.
	localparam logic [11:0] IDX_RST   = 12'h01f;
	localparam logic [11:0] IDX_PHASE = 12'h042;
	localparam logic [11:0] IDX_VR    = 12'h0d0;
	localparam logic [11:0] IDX_CLD   = 12'h155;
	localparam logic [11:0] ADDR_RST   = {IDX_RST[9:0], 2'b00};
	localparam logic [11:0] ADDR_PHASE = {IDX_PHASE[9:0], 2'b00};
	localparam logic [11:0] ADDR_VR    = {IDX_VR[9:0], 2'b00};
	localparam logic [11:0] ADDR_CLD   = {IDX_CLD[9:0], 2'b00};

	// Bit positions of the single-bit controls and flags.
	localparam int BIT_SWRST     = 15;
	localparam int BIT_RESTART   = 14;
	localparam int BIT_PH_EN     = 4;
	localparam int BIT_VR_PD     = 15;
	localparam int BIT_CLD_START = 15;
	localparam int BIT_CLD_DONE  = 12;

	// Field positions.
	localparam int PH_MSB   = 3;
	localparam int VRR_MSB  = 14;
	localparam int VRR_LSB  = 4;
	localparam int VRC_MSB  = 3;
	localparam int RES_MSB  = 11;
	localparam int RES_LSB  = 4;
	localparam int AVG_MSB  = 2;

	// Reset values.
	localparam logic [3:0]  PHASE_RST   = 4'h0;
	localparam logic [10:0] VR_RSVD_RST = 11'h000;
	localparam logic [3:0]  VR_CTRL_RST = 4'h0;
	localparam logic [2:0]  CLD_AVG_RST = 3'h1;
	localparam logic [7:0]  CLD_RES_RST = 8'h00;

	// Phase range: one step is 4 ns, ten steps span 40 ns.
	localparam logic [3:0] PHASE_LIMIT   = 4'ha;
	localparam int         PHASE_STEP_NS = 4;

	// Internal reset hold and the settle time between two delay steps.
	localparam int RESET_HOLD_NS  = 100;
	localparam int RESET_HOLD_CYC =
		(RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STEP_SETTLE_NS = 40;
	localparam int STEP_GAP_CYC   =
		(STEP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Clear levels issued by the reset sequencer.
	typedef struct packed {
		logic core_clr;   // Whole device, registers included.
		logic circ_clr;   // Circuitry only, registers kept.
	} phyctl_rst_t;

	// Folds a phase value above the limit back into range (modulo ten).
	function automatic logic [3:0] phyctl_mod10(input logic [3:0] v);
		phyctl_mod10 = (v >= PHASE_LIMIT) ? 4'(v - PHASE_LIMIT) : v;
	endfunction : phyctl_mod10

endpackage : phyctl_pkg

// [src/phyctl_rstseq.sv]
// Purpose: Stretches software reset and restart pulses into clear levels.
// Assumes: Pulses are one cycle wide and synchronous to clk.
// Notes:   A restart during a running software reset is absorbed by it.
module phyctl_rstseq
	import phyctl_pkg::*;
#(
	parameter int HOLD = RESET_HOLD_CYC
) (
	input  wire logic  clk,
	input  wire logic  resetn,
	input  wire logic  sw_reset,
	input  wire logic  restart,
	output phyctl_rst_t clr
);

	localparam int CW = $clog2(HOLD + 1);

	logic [CW-1:0] cnt;   // Remaining hold cycles after this one.

	// Each request holds its clear for HOLD cycles; reset outranks restart.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cnt <= '0;
			clr <= '0;
		end else if (sw_reset) begin
			cnt          <= CW'(HOLD - 1);
			clr.core_clr <= 1'b1;
			clr.circ_clr <= 1'b1;
		end else if (restart && !clr.core_clr) begin
			cnt          <= CW'(HOLD - 1);
			clr.circ_clr <= 1'b1;
		end else if (cnt != '0) begin
			cnt <= cnt - 1'b1;
		end else begin
			clr <= '0;
		end
	end

endmodule : phyctl_rstseq

// [src/phyctl_phstep.sv]
// Purpose: Walks the applied transmit clock phase toward its goal.
// Assumes: The delay line takes one 4 ns step per step pulse.
// Notes:   Steps are spaced so the delay line settles between them.
module phyctl_phstep
	import phyctl_pkg::*;
#(
	parameter int GAP = STEP_GAP_CYC
) (
	input  wire logic       clk,
	input  wire logic       resetn,
	input  wire logic       clr,
	input  wire logic       go,
	input  wire logic [3:0] target,
	output logic [3:0]      applied,
	output logic            step,
	output logic            up
);

	localparam int GW = $clog2(GAP + 1);

	logic [3:0]    goal;   // Phase the delay line is heading for.
	logic [GW-1:0] gap;    // Settle cycles still to wait.

	// The goal moves when software applies a new value or a clear returns it to zero.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			goal <= PHASE_RST;
		end else if (clr) begin
			goal <= PHASE_RST;
		end else if (go) begin
			goal <= target;
		end
	end

	// One step per settle window; the move totals the phase difference.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			applied <= PHASE_RST;
			gap     <= '0;
			step    <= 1'b0;
			up      <= 1'b0;
		end else if (clr) begin
			applied <= PHASE_RST;
			gap     <= '0;
			step    <= 1'b0;
		end else if (gap != '0) begin
			gap  <= gap - 1'b1;
			step <= 1'b0;
		end else if (applied != goal) begin
			step    <= 1'b1;
			up      <= goal > applied;
			applied <= (goal > applied) ? applied + 1'b1 : applied - 1'b1;
			gap     <= GW'(GAP - 1);
		end else begin
			step <= 1'b0;
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);

	// The step pulse and the phase move leave the same edge, so a change
	// of the applied phase outside a clear must come with the step pulse beside it.
	chk_phase_fixed: assert property (
		!clr |=> step || $stable(applied))
		else $error("Applied phase moved without a step.");
	chk_step_spacing: assert property (
		step |=> !step [*2])
		else $error("Delay steps came closer than the settle time.");

endmodule : phyctl_phstep

// [test/tb_phy_reset_clkphase_ctrl_regs.sv]
// Purpose: Self-checking bench for the transceiver control registers.
// Assumes: APB slave answers through PREADY; one 100 MHz clock.
// Notes:   An integer model predicts the check_all reads and the steady outputs.
module tb_phy_reset_clkphase_ctrl_regs
	import phyctl_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	logic        CLK, RESETN;              // Clock and async reset.
	logic        PSEL, PENABLE, PWRITE;    // APB controls.
	logic [11:0] PADDR;                    // APB byte address.
	logic [31:0] PWDATA, PRDATA;           // APB data.
	logic        PREADY, PSLVERR;          // APB answer.
	logic        CORE_RESETN, RESTART_N;   // Reset levels.
	logic [3:0]  TX_PHASE, REG_CTRL;       // Phase and regulator field.
	logic        TX_PHASE_STEP, TX_PHASE_UP;
	logic        REG_POWER_DOWN, CLD_START;
	logic [2:0]  CLD_AVG;                  // Averaging factor.
	logic        CLD_DONE, CLD_RESULT_VALID;
	logic [7:0]  CLD_RESULT;               // Engine result.
	logic [31:0] rdata, seed;              // Last read data and LFSR.
	logic        slverr;                   // Last error answer.
	int          error_cnt, comparisons;   // Verdict counters.
	int          steps, starts, core_lo, rst_lo; // Event counts.
	int          m_phase, m_vrc, m_avg, m_res, m_done; // Model state.

	// Galois-free shift register; cheap and repeatable stimulus.
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr_next

	// Free-running clock of the single domain.
	initial begin
		CLK = 1'b0;
		forever #(CLK_PERIOD_NS / 2) CLK = ~CLK;
	end

	phyctl_regs phyctl_regs_i (
		.CLK              (CLK),
		.RESETN           (RESETN),
		.PSEL             (PSEL),
		.PENABLE          (PENABLE),
		.PWRITE           (PWRITE),
		.PADDR            (PADDR),
		.PWDATA           (PWDATA),
		.PRDATA           (PRDATA),
		.PREADY           (PREADY),
		.PSLVERR          (PSLVERR),
		.CORE_RESETN      (CORE_RESETN),
		.RESTART_N        (RESTART_N),
		.TX_PHASE         (TX_PHASE),
		.TX_PHASE_STEP    (TX_PHASE_STEP),
		.TX_PHASE_UP      (TX_PHASE_UP),
		.REG_POWER_DOWN   (REG_POWER_DOWN),
		.REG_CTRL         (REG_CTRL),
		.CLD_START        (CLD_START),
		.CLD_AVG          (CLD_AVG),
		.CLD_DONE         (CLD_DONE),
		.CLD_RESULT_VALID (CLD_RESULT_VALID),
		.CLD_RESULT       (CLD_RESULT)
	);

	// Counts pulses and held-low cycles; tasks compare differences only.
	always @(posedge CLK) begin
		if (TX_PHASE_STEP === 1'b1) steps++;
		if (CLD_START === 1'b1) starts++;
		if (RESETN === 1'b1 && CORE_RESETN === 1'b0) core_lo++;
		if (RESETN === 1'b1 && RESTART_N === 1'b0) rst_lo++;
	end

	// Compares one value and counts the comparison.
	task automatic check(input logic [31:0] got, input logic [31:0] exp,
		input string what);
		comparisons++;
		if (got !== exp) begin
			$display("wrong value at %0t ns: %s got %h want %h",
				$time, what, got, exp);
			error_cnt++;
		end
	endtask : check

	// Prints the verdict and stops the run.
	task automatic tally_and_finish;
		if (error_cnt == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : tally_and_finish

	// A wait that ran out is a mismatch and ends the run.
	task automatic timeout;
		$display("wrong value at %0t ns: wait ran out", $time);
		error_cnt++;
		tally_and_finish();
	endtask : timeout

	// One APB transfer; the request holds until PREADY is seen high.
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		@(posedge CLK);
		PSEL   <= 1'b1;
		PWRITE <= w;
		PADDR  <= a;
		PWDATA <= d;
		@(posedge CLK);
		PENABLE <= 1'b1;
		n = 0;
		do begin
			@(posedge CLK);
			n++;
		end while (PREADY !== 1'b1 && n < 50);
		if (PREADY !== 1'b1)
			timeout();
		rdata  = PRDATA;
		slverr = PSLVERR;
		PSEL    <= 1'b0;
		PENABLE <= 1'b0;
	endtask : apb

	// Reads a register and compares it with the model.
	task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp,
		input string what);
		apb(1'b0, a, 32'h0);
		check(rdata, exp, what);
		check({31'h0, slverr}, 32'h0, "slave error");
	endtask : rd_chk

	// Reads every register and compares the steady outputs.
	task automatic check_all;
		rd_chk(ADDR_RST, 32'h0, "reset ctrl");
		rd_chk(ADDR_PHASE, 32'(m_phase), "phase");
		rd_chk(ADDR_VR, 32'(m_vrc), "regulator");
		rd_chk(ADDR_CLD, 32'(m_done * 4096 + m_res * 16 + m_avg), "diag");
		check(32'(CLD_AVG), 32'(m_avg), "avg out");
		check(32'(REG_CTRL), 32'(m_vrc), "reg ctrl out");
		check(32'(TX_PHASE), 32'(m_phase), "tx phase");
	endtask : check_all

	// Applies a phase and checks the number and direction of steps.
	task automatic phase_apply(input logic [3:0] v);
		int goal, n, b;
		goal = v % 10;
		b = steps;
		apb(1'b1, ADDR_PHASE, {27'h0, 1'b1, v});
		n = 0;
		while (TX_PHASE !== 4'(goal) && n < 200) begin
			@(posedge CLK);
			n++;
		end
		if (n >= 200)
			timeout();
		repeat (8) @(posedge CLK);
		check(32'(steps - b), 32'(goal > m_phase ? goal - m_phase
			: m_phase - goal), "step count");
		if (goal != m_phase)
			check({31'h0, TX_PHASE_UP}, 32'(goal > m_phase), "dir");
		m_phase = goal;
		check_all();
	endtask : phase_apply

	// Hands one engine result over with a single valid pulse.
	task automatic pulse_result(input logic [7:0] r);
		@(posedge CLK);
		CLD_RESULT       <= r;
		CLD_RESULT_VALID <= 1'b1;
		CLD_DONE         <= 1'b1;
		@(posedge CLK);
		CLD_RESULT_VALID <= 1'b0;
		CLD_RESULT       <= ~r;
		m_res  = r;
		m_done = 1;
	endtask : pulse_result

	// Main sequence: reset, refusals, phase walks, resets.
	initial begin
		int b, c;
		{PSEL, PENABLE, PWRITE, PADDR, PWDATA} = '0;
		{RESETN, CLD_DONE, CLD_RESULT_VALID, CLD_RESULT} = '0;
		{error_cnt, comparisons, steps, starts, core_lo, rst_lo} = '0;
		{m_phase, m_vrc, m_res, m_done} = '0;
		m_avg = 1;
		seed = 32'h00012056;
		repeat (20) @(posedge CLK);
		RESETN <= 1'b1;
		check_all();
		// Unmapped place: refused, reads zero, changes nothing.
		apb(1'b1, 12'h004, 32'hffff);
		check({31'h0, slverr}, 32'h1, "unmapped write");
		apb(1'b0, 12'h004, 32'h0);
		check({slverr, rdata[30:0]}, 32'h80000000, "unmapped read");
		// No reset, restart, enable or start bit set: no reset, no start, no move.
		b = starts;
		apb(1'b1, ADDR_RST, 32'h3fff);
		apb(1'b1, ADDR_PHASE, 32'hffe5);
		apb(1'b1, ADDR_CLD, 32'h6ff9);
		repeat (4) @(posedge CLK);
		check(32'(core_lo + rst_lo + starts - b), 32'h0, "side effect");
		check_all();
		phase_apply(4'h2);
		phase_apply(4'h9);
		phase_apply(4'hd);
		phase_apply(4'h3);
		for (int i = 0; i < 6; i++) begin
			seed = lfsr_next(seed);
			phase_apply(seed[3:0]);
			apb(1'b0, ADDR_VR, 32'h0);
			m_vrc = seed[7:4];
			apb(1'b1, ADDR_VR, {28'h0, seed[7:4]});
			m_avg = seed[10:8];
			b = starts;
			apb(1'b1, ADDR_CLD, {16'h0, 1'(i % 2), 12'h0, seed[10:8]});
			pulse_result(seed[19:12]);
			repeat (3) @(posedge CLK);
			check(32'(starts - b), 32'(i % 2), "start pulse");
			check_all();
		end
		apb(1'b1, ADDR_VR, 32'(32'h8000 + m_vrc));
		@(posedge CLK);
		check({31'h0, REG_POWER_DOWN}, 32'h1, "power down");
		check_all();
		// Restart keeps registers; only the circuitry level drops.
		b = rst_lo;
		c = core_lo;
		apb(1'b1, ADDR_RST, 32'h4000);
		repeat (20) @(posedge CLK);
		check(32'(rst_lo - b), 32'(RESET_HOLD_CYC), "restart");
		check(32'(core_lo - c), 32'h0, "restart core");
		check_all();
		// Software reset clears everything but TX_PHASE_UP as the pin would.
		b = rst_lo;
		c = core_lo;
		apb(1'b1, ADDR_RST, 32'h8000);
		repeat (20) @(posedge CLK);
		check(32'(core_lo - c), 32'(RESET_HOLD_CYC), "soft core");
		check(32'(rst_lo - b), 32'(RESET_HOLD_CYC), "soft restart");
		check({31'h0, REG_POWER_DOWN}, 32'h0, "pd cleared");
		{m_phase, m_vrc, m_res} = '0;
		m_avg = 1;
		check_all();
		tally_and_finish();
	end

endmodule : tb_phy_reset_clkphase_ctrl_regs
